// ### shadow_regs_pkg.sv
/*
  Constants shared by the shadow register block: register indices, bit
  positions of device control, drive/head and error, frame type codes and
  frame field positions. Assumes an 8-bit shadow register access path.
*/
package shadow_regs_pkg;

  // register indices on the shadow access port
  localparam logic [3:0] REG_DATA           = 4'h0;
  localparam logic [3:0] REG_ERROR          = 4'h1;
  localparam logic [3:0] REG_SECTOR_COUNT   = 4'h2;
  localparam logic [3:0] REG_ADDR_LOW       = 4'h3;
  localparam logic [3:0] REG_ADDR_MID       = 4'h4;
  localparam logic [3:0] REG_ADDR_HIGH      = 4'h5;
  localparam logic [3:0] REG_DRIVE_HEAD     = 4'h6;
  localparam logic [3:0] REG_COMMAND        = 4'h7;
  localparam logic [3:0] REG_DEVICE_CONTROL = 4'h8;
  localparam logic [3:0] REG_CMD_BLOCK_LAST = 4'h7;

  // device control bits
  localparam int CTL_HOB  = 7;
  localparam int CTL_HOST_SOFT_RESET = 2;
  localparam int CTL_INTERRUPT_DISABLE_N = 1;

  // drive/head bits
  localparam int DH_LBA_MODE = 6;
  localparam int DH_DEV      = 4;
  localparam int DH_HEAD_MSB = 3;

  // error register bits
  localparam int ERR_INTERFACE_CRC_ERROR  = 7;
  localparam int ERR_UNC   = 6;
  localparam int ERR_SECTOR_ID_NOT_FOUND  = 4;
  localparam int ERR_COMMAND_ABORTED  = 2;
  localparam int ERR_TRACK_ZERO_NOT_FOUND = 1;
  localparam int ERR_ADDRESS_MARK_NOT_FOUND  = 0;

  localparam int STATUS_BUSY = 7;

  // frame type codes
  localparam logic [7:0] FRAME_DMA_ACTIVATE = 8'h39;
  localparam logic [7:0] FRAME_DMA_SETUP    = 8'h41;
  localparam logic [7:0] FRAME_SET_DEV_BITS = 8'hA1;

  // frame word 0 flag and field positions
  localparam int FW_AUTO_ACT = 15;
  localparam int FW_NOTIFY   = 15;
  localparam int FW_IRQ      = 14;
  localparam int FW_DIR      = 13;
  localparam int FW_STAT_LO  = 16;
  localparam int FW_STAT_HI  = 20;
  localparam int FW_ERROR    = 24;

  localparam logic [2:0] LEN_DMA_ACTIVATE = 3'd1;
  localparam logic [2:0] LEN_DMA_SETUP    = 3'd7;
  localparam logic [2:0] LEN_SET_DEV_BITS = 3'd2;

  localparam logic [7:0] RESET_DRIVE_HEAD = 8'h00;
  localparam logic [7:0] RESET_CONTROL    = 8'h00;

  typedef enum logic [1:0] {F_IDLE, F_SEND} frame_state_e;

endpackage : shadow_regs_pkg

// ### sata_shadow_register_block.sv
/*
  Device-side shadow register block: command launch, device control,
  drive/head, error flags, address bytes with 24-bit previous contents, and a
  word-serial builder for DMA activate, DMA setup and set-device-bits frames.
  Assumes the link layer delivers register accesses and drains frame words on
  the same clock, and that command execution logic reports events and
  completion with the current address.
*/
`timescale 1ns/1ps

module sata_shadow_register_block #(
  parameter logic DEVICE_NUMBER = 1'b0,
  parameter int   TAG_WIDTH     = 5
) (
  input  wire logic                  clk,
  input  wire logic                  rst,
  // shadow register access
  input  wire logic                  reg_wr,
  input  wire logic                  reg_rd,
  input  wire logic [3:0]            reg_sel,
  input  wire logic [7:0]            reg_wdata,
  output logic      [7:0]            reg_rdata,
  output logic                       reg_rvalid,
  // command execution side
  output logic                       cmd_start,
  output logic      [7:0]            cmd_code,
  output logic                       busy_flag,
  output logic                       lba_mode,
  output logic                       device_select,
  output logic                       soft_reset_active,
  output logic                       frame_irq_force,
  output logic                       intrq,
  input  wire logic [6:0]            status_low,
  input  wire logic                  cmd_done,
  input  wire logic                  cmd_done_ext,
  input  wire logic [47:0]           current_lba,
  input  wire logic                  interface_crc_error,
  input  wire logic                  uncorrectable_data_error,
  input  wire logic                  sector_id_not_found,
  input  wire logic                  command_aborted,
  input  wire logic                  track_zero_not_found,
  input  wire logic                  address_mark_not_found,
  // frame requests
  input  wire logic                  send_dma_activate,
  input  wire logic                  send_dma_setup,
  input  wire logic                  setup_direction,
  input  wire logic                  setup_auto_activate,
  input  wire logic                  setup_irq,
  input  wire logic [TAG_WIDTH-1:0]  setup_tag,
  input  wire logic [31:0]           setup_buffer_offset,
  input  wire logic [31:0]           setup_transfer_count,
  input  wire logic                  send_set_dev_bits,
  input  wire logic [7:0]            sdb_error,
  input  wire logic [2:0]            sdb_status_hi,
  input  wire logic [2:0]            sdb_status_lo,
  input  wire logic                  sdb_notify,
  input  wire logic                  sdb_irq,
  input  wire logic [31:0]           sdb_active_mask,
  output logic                       frame_req_ready,
  // frame word stream toward the link
  output logic                       frame_valid,
  output logic      [31:0]           frame_word,
  output logic                       frame_last,
  input  wire logic                  frame_ready
);
  import shadow_regs_pkg::*;

  // register state
  logic [7:0]  control;
  logic [7:0]  drive_head;
  logic [7:0]  error_flags;
  logic [7:0]  addr_low;
  logic [7:0]  addr_mid;
  logic [7:0]  addr_high;
  logic [7:0]  addr_low_prev;
  logic [7:0]  addr_mid_prev;
  logic [7:0]  addr_high_prev;
  logic        busy;
  logic        irq_pending;

  // access decode
  wire logic        wr_control   = reg_wr && (reg_sel == REG_DEVICE_CONTROL);
  wire logic        cmd_block_wr = reg_wr && (reg_sel <= REG_CMD_BLOCK_LAST);
  wire logic        wr_accepted  = cmd_block_wr && !busy;
  wire logic        wr_command   = wr_accepted && (reg_sel == REG_COMMAND);
  wire logic        wr_low       = wr_accepted && (reg_sel == REG_ADDR_LOW);
  wire logic        wr_mid       = wr_accepted && (reg_sel == REG_ADDR_MID);
  wire logic        wr_high      = wr_accepted && (reg_sel == REG_ADDR_HIGH);
  wire logic        wr_dh        = wr_accepted && (reg_sel == REG_DRIVE_HEAD);
  wire logic        host_soft_reset         = control[CTL_HOST_SOFT_RESET];
  wire logic        high_order_byte_select          = control[CTL_HOB];
  wire logic        interrupt_disable_n         = control[CTL_INTERRUPT_DISABLE_N];
  wire logic        rd_status    = reg_rd && (reg_sel == REG_COMMAND);
  wire logic [7:0]  status_byte  = {busy, status_low};

  // control register: writes take effect at once
  wire logic [7:0]  next_control =
    wr_control   ? reg_wdata :
    cmd_block_wr ? (control & ~(8'h01 << CTL_HOB)) : control;

  always_ff @(posedge clk or posedge rst) begin
    if (rst) begin
      control <= RESET_CONTROL;
    end else begin
      control <= next_control;
    end
  end

  // busy: soft reset raises it with the control bit, release frees it at once
  wire logic host_soft_reset_release = host_soft_reset && !next_control[CTL_HOST_SOFT_RESET];
  wire logic next_busy    = next_control[CTL_HOST_SOFT_RESET] ? 1'b1 :
                            host_soft_reset_release ? 1'b0 :
                            wr_command ? 1'b1 :
                            cmd_done ? 1'b0 : busy;

  always_ff @(posedge clk or posedge rst) begin
    if (rst) begin
      busy <= 1'b0;
    end else begin
      busy <= next_busy;
    end
  end

  // command launch pulse
  always_ff @(posedge clk or posedge rst) begin
    if (rst) begin
      cmd_start <= 1'b0;
      cmd_code  <= 8'h00;
    end else begin
      cmd_start <= wr_command && !host_soft_reset;
      if (wr_command) begin
        cmd_code <= reg_wdata;
      end
    end
  end

  // error flags: events set, next command clears, set wins
  logic [7:0] err_events;
  always_comb begin
    err_events            = 8'h00;
    err_events[ERR_INTERFACE_CRC_ERROR]  = interface_crc_error;
    err_events[ERR_UNC]   = uncorrectable_data_error;
    err_events[ERR_SECTOR_ID_NOT_FOUND]  = sector_id_not_found;
    err_events[ERR_COMMAND_ABORTED]  = command_aborted;
    err_events[ERR_TRACK_ZERO_NOT_FOUND] = track_zero_not_found;
    err_events[ERR_ADDRESS_MARK_NOT_FOUND]  = address_mark_not_found;
  end

  wire logic [7:0] next_error =
    host_soft_reset ? 8'h00 : ((wr_command ? 8'h00 : error_flags) | err_events);

  always_ff @(posedge clk or posedge rst) begin
    if (rst) begin
      error_flags <= 8'h00;
    end else begin
      error_flags <= next_error;
    end
  end

  // drive/head: written value live at once, head bits refreshed at completion
  wire logic [7:0] next_dh =
    host_soft_reset ? RESET_DRIVE_HEAD :
    wr_dh ? reg_wdata :
    cmd_done ? {drive_head[7:DH_HEAD_MSB+1], current_lba[27:24]} :
    drive_head;

  always_ff @(posedge clk or posedge rst) begin
    if (rst) begin
      drive_head <= RESET_DRIVE_HEAD;
    end else begin
      drive_head <= next_dh;
    end
  end

  // address bytes: a write pushes the old value into the previous slot
  always_ff @(posedge clk or posedge rst) begin
    if (rst) begin
      addr_low       <= 8'h00;
      addr_mid       <= 8'h00;
      addr_high      <= 8'h00;
      addr_low_prev  <= 8'h00;
      addr_mid_prev  <= 8'h00;
      addr_high_prev <= 8'h00;
    end else if (cmd_done) begin
      addr_low  <= current_lba[7:0];
      addr_mid  <= current_lba[15:8];
      addr_high <= current_lba[23:16];
      if (cmd_done_ext) begin
        addr_low_prev  <= current_lba[31:24];
        addr_mid_prev  <= current_lba[39:32];
        addr_high_prev <= current_lba[47:40];
      end
    end else begin
      if (wr_low) begin
        addr_low_prev <= addr_low;
        addr_low      <= reg_wdata;
      end
      if (wr_mid) begin
        addr_mid_prev <= addr_mid;
        addr_mid      <= reg_wdata;
      end
      if (wr_high) begin
        addr_high_prev <= addr_high;
        addr_high      <= reg_wdata;
      end
    end
  end

  // read mux: busy returns status for every register
  wire logic [7:0] err_view = error_flags & 8'hD7;
  logic [7:0] rd_sel_data;
  always_comb begin
    case (reg_sel)
      REG_ERROR:      rd_sel_data = err_view;
      REG_ADDR_LOW:   rd_sel_data = high_order_byte_select ? addr_low_prev : addr_low;
      REG_ADDR_MID:   rd_sel_data = high_order_byte_select ? addr_mid_prev : addr_mid;
      REG_ADDR_HIGH:  rd_sel_data = high_order_byte_select ? addr_high_prev : addr_high;
      REG_DRIVE_HEAD: rd_sel_data = drive_head;
      REG_COMMAND:    rd_sel_data = status_byte;
      default:        rd_sel_data = 8'h00;
    endcase
  end
  wire logic [7:0] next_rdata = busy ? status_byte : rd_sel_data;

  always_ff @(posedge clk or posedge rst) begin
    if (rst) begin
      reg_rdata  <= 8'h00;
      reg_rvalid <= 1'b0;
    end else begin
      reg_rvalid <= reg_rd;
      if (reg_rd) begin
        reg_rdata <= next_rdata;
      end
    end
  end

  // interrupt: completion sets, status read or new command clears, set wins
  wire logic selected       = (drive_head[DH_DEV] == DEVICE_NUMBER);
  wire logic next_irq_pend  = host_soft_reset ? 1'b0 :
                              cmd_done ? 1'b1 :
                              ((rd_status && !busy) || wr_command) ? 1'b0 : irq_pending;

  always_ff @(posedge clk or posedge rst) begin
    if (rst) begin
      irq_pending <= 1'b0;
      intrq       <= 1'b0;
    end else begin
      irq_pending <= next_irq_pend;
      intrq       <= next_irq_pend && !interrupt_disable_n && selected;
    end
  end

  // mode and status outputs
  always_ff @(posedge clk or posedge rst) begin
    if (rst) begin
      busy_flag         <= 1'b0;
      lba_mode          <= 1'b0;
      device_select     <= 1'b0;
      soft_reset_active <= 1'b0;
      frame_irq_force   <= 1'b0;
    end else begin
      busy_flag         <= next_busy;
      lba_mode          <= next_dh[DH_LBA_MODE];
      device_select     <= next_dh[DH_DEV];
      soft_reset_active <= next_control[CTL_HOST_SOFT_RESET];
      frame_irq_force   <= next_control[CTL_INTERRUPT_DISABLE_N];
    end
  end

  // frame builder
  frame_state_e fstate;
  logic [31:0]  fwords [0:6];
  logic [2:0]   flen;
  logic [2:0]   fidx;

  logic [31:0] act_w0;
  logic [31:0] setup_w0;
  logic [31:0] setup_w1;
  logic [31:0] sdb_w0;
  always_comb begin
    act_w0                  = {24'h000000, FRAME_DMA_ACTIVATE};
    setup_w0                = {24'h000000, FRAME_DMA_SETUP};
    setup_w0[FW_AUTO_ACT]   = setup_auto_activate;
    setup_w0[FW_DIR]        = setup_direction;
    setup_w0[FW_IRQ]        = setup_irq || interrupt_disable_n;
    setup_w1                = 32'h00000000;
    setup_w1[TAG_WIDTH-1:0] = setup_tag;
    sdb_w0                  = {24'h000000, FRAME_SET_DEV_BITS};
    sdb_w0[FW_ERROR +: 8]   = sdb_error;
    sdb_w0[FW_STAT_HI +: 3] = sdb_status_hi;
    sdb_w0[FW_STAT_LO +: 3] = sdb_status_lo;
    sdb_w0[FW_NOTIFY]       = sdb_notify;
    sdb_w0[FW_IRQ]          = sdb_irq || interrupt_disable_n;
  end

  wire logic any_req  = send_dma_activate || send_dma_setup || send_set_dev_bits;
  wire logic take_req = (fstate == F_IDLE) && any_req && !host_soft_reset;
  wire logic word_out = frame_valid && frame_ready;
  wire logic [2:0] next_fidx = fidx + 3'd1;

  always_ff @(posedge clk or posedge rst) begin
    if (rst) begin
      fstate <= F_IDLE;
      flen   <= 3'd0;
      fidx   <= 3'd0;
    end else begin
      case (fstate)
        F_IDLE: begin
          fidx <= 3'd0;
          if (take_req) begin
            fstate <= F_SEND;
            flen   <= send_dma_activate ? LEN_DMA_ACTIVATE :
                      send_dma_setup    ? LEN_DMA_SETUP : LEN_SET_DEV_BITS;
          end
        end
        F_SEND: begin
          if (word_out) begin
            fidx <= next_fidx;
            if (next_fidx == flen) begin
              fstate <= F_IDLE;
            end
          end
        end
        default: fstate <= F_IDLE;
      endcase
    end
  end

  // frame word storage, loaded when a request is taken
  always_ff @(posedge clk) begin
    if (take_req) begin
      if (send_dma_activate) begin
        fwords[0] <= act_w0;
      end else if (send_dma_setup) begin
        fwords[0] <= setup_w0;
        fwords[1] <= setup_w1;
        fwords[2] <= 32'h00000000;
        fwords[3] <= 32'h00000000;
        fwords[4] <= setup_buffer_offset;
        fwords[5] <= setup_transfer_count;
        fwords[6] <= 32'h00000000;
      end else begin
        fwords[0] <= sdb_w0;
        fwords[1] <= sdb_active_mask;
      end
    end
  end

  // registered stream outputs
  wire logic        next_fvalid = (fstate == F_SEND) && !(word_out && next_fidx == flen);
  wire logic [2:0]  out_idx     = (fstate == F_SEND && word_out) ? next_fidx : 3'd0;

  always_ff @(posedge clk or posedge rst) begin
    if (rst) begin
      frame_valid     <= 1'b0;
      frame_word      <= 32'h00000000;
      frame_last      <= 1'b0;
      frame_req_ready <= 1'b0;
    end else begin
      frame_req_ready <= (fstate == F_IDLE) && !take_req && !host_soft_reset;
      if (take_req) begin
        frame_valid <= 1'b1;
        frame_word  <= send_dma_activate ? act_w0 : send_dma_setup ? setup_w0 : sdb_w0;
        frame_last  <= send_dma_activate;
      end else if (fstate == F_SEND && word_out) begin
        frame_valid <= next_fvalid;
        frame_word  <= next_fvalid ? fwords[out_idx] : 32'h00000000;
        frame_last  <= next_fvalid && ((next_fidx + 3'd1) == flen);
      end
    end
  end

endmodule : sata_shadow_register_block

// ### shadow_regs_sva.sv
/*
  Port-level checker for the shadow register block.
  Assumes the block's single clk and its asynchronous active-high rst.
*/
`timescale 1ns/1ps
module shadow_regs_sva #(
  parameter logic DEVICE_NUMBER = 1'b0
) (
  input wire logic        clk,
  input wire logic        rst,
  input wire logic        reg_wr,
  input wire logic        reg_rd,
  input wire logic [3:0]  reg_sel,
  input wire logic [7:0]  reg_wdata,
  input wire logic [7:0]  reg_rdata,
  input wire logic        reg_rvalid,
  input wire logic        cmd_start,
  input wire logic [7:0]  cmd_code,
  input wire logic        busy_flag,
  input wire logic        device_select,
  input wire logic        soft_reset_active,
  input wire logic        frame_irq_force,
  input wire logic        intrq,
  input wire logic [6:0]  status_low,
  input wire logic        cmd_done,
  input wire logic        send_dma_activate,
  input wire logic        frame_req_ready,
  input wire logic        frame_valid,
  input wire logic [31:0] frame_word,
  input wire logic        frame_last
);
  import shadow_regs_pkg::*;
  default clocking cb @(posedge clk);
  endclocking
  default disable iff (rst);

  AST_CMD_START: assert property (reg_wr && reg_sel == REG_COMMAND && !busy_flag
    |=> cmd_start && busy_flag && cmd_code == $past(reg_wdata)) else $error("command write did not launch");
  AST_BUSY_READ: assert property (reg_rd && busy_flag
    |=> reg_rvalid && reg_rdata == {1'b1, $past(status_low)}) else $error("busy read not answered with status");
  AST_ERR_ZERO: assert property (reg_rd && reg_sel == REG_ERROR && !busy_flag
    |=> reg_rdata[5] == 1'b0 && reg_rdata[3] == 1'b0) else $error("error bits 5 or 3 set");
  AST_IRQ_MASK: assert property (frame_irq_force && $past(frame_irq_force) |-> !intrq)
    else $error("interrupt raised while disabled");
  AST_IRQ_DEV: assert property (device_select != DEVICE_NUMBER && $past(device_select) != DEVICE_NUMBER
    |-> !intrq) else $error("interrupt raised while other device selected");
  AST_DONE_IRQ: assert property (cmd_done && busy_flag && !soft_reset_active && !frame_irq_force
    && device_select == DEVICE_NUMBER |=> !busy_flag && intrq) else $error("completion missed interrupt");
  AST_HOST_SOFT_RESET_HOLD: assert property (soft_reset_active && $past(soft_reset_active)
    |-> busy_flag && !cmd_start) else $error("soft reset not holding busy");
  AST_HOST_SOFT_RESET_FREE: assert property ($fell(soft_reset_active) |=> !busy_flag)
    else $error("busy not freed after soft reset");
  AST_ACTIVATE: assert property (send_dma_activate && frame_req_ready && !frame_valid && !soft_reset_active
    |=> frame_valid && frame_last && frame_word == {24'h0, FRAME_DMA_ACTIVATE}) else $error("bad activate frame");
endmodule : shadow_regs_sva

bind sata_shadow_register_block shadow_regs_sva #(.DEVICE_NUMBER(DEVICE_NUMBER)) shadow_regs_sva_i (
  .clk, .rst, .reg_wr, .reg_rd, .reg_sel, .reg_wdata, .reg_rdata, .reg_rvalid, .cmd_start, .cmd_code,
  .busy_flag, .device_select, .soft_reset_active, .frame_irq_force, .intrq, .status_low, .cmd_done,
  .send_dma_activate, .frame_req_ready, .frame_valid, .frame_word, .frame_last);

// ### frame_sink.sv
/*
  Link-side sink for the frame word stream, accepting at once or with stalls.
  Assumes it shares clk and rst with the shadow register block.
*/
`timescale 1ns/1ps
module frame_sink (
  input  wire logic slow,
  input  wire logic clk,
  input  wire logic rst,
  output logic      frame_ready
);
  logic [7:0] lfsr;

  // pseudo-random stalls while slow
  always @(posedge clk or posedge rst) begin
    if (rst) begin
      lfsr <= 8'hA5;
      frame_ready <= 1'b0;
    end else begin
      lfsr <= {lfsr[6:0], lfsr[7] ^ lfsr[5] ^ lfsr[4] ^ lfsr[3]};
      frame_ready <= #1 !slow | lfsr[0];
    end
  end
endmodule : frame_sink

// ### tb_sata_shadow_register_block.sv
/*
  Self-checking bench: register accesses, command runs, soft reset, frames.
  Assumes the package, the block, the checker and the frame sink are compiled first.
*/
`timescale 1ns/1ps
module tb_sata_shadow_register_block;
  import shadow_regs_pkg::*;
  logic        clk = 1'b0, rst = 1'b1, reg_wr = 1'b0, reg_rd = 1'b0, cmd_done = 1'b0, cmd_done_ext = 1'b0;
  logic        send_dma_activate = 1'b0, send_dma_setup = 1'b0, send_set_dev_bits = 1'b0, slow = 1'b0;
  logic        setup_direction = 1'b0, setup_auto_activate = 1'b0, setup_irq = 1'b0, sdb_notify = 1'b0;
  logic        sdb_irq = 1'b0, reg_rvalid, cmd_start, busy_flag, lba_mode, device_select, soft_reset_active;
  logic        frame_irq_force, intrq, frame_req_ready, frame_valid, frame_last, frame_ready, interrupt_disable_n, dev;
  logic [3:0]  reg_sel = 4'h0;
  logic [7:0]  reg_wdata = 8'h00, sdb_error = 8'h00, code, reg_rdata, cmd_code;
  logic [6:0]  status_low = 7'h00;
  logic [5:0]  err_in = 6'h00;
  logic [4:0]  setup_tag = 5'h00;
  logic [2:0]  sdb_status_hi = 3'h0, sdb_status_lo = 3'h0;
  logic [31:0] setup_buffer_offset = 32'h0, setup_transfer_count = 32'h0, sdb_active_mask = 32'h0, frame_word;
  logic [47:0] current_lba = 48'h0, lba;
  logic [7:0]  exp_rd [$];
  logic [32:0] exp_fr [$];
  int          seed = 49, failures = 0, cmp_count = 0;
  int          ebit [6] = '{ERR_ADDRESS_MARK_NOT_FOUND, ERR_TRACK_ZERO_NOT_FOUND, ERR_COMMAND_ABORTED, ERR_SECTOR_ID_NOT_FOUND, ERR_UNC, ERR_INTERFACE_CRC_ERROR};

  sata_shadow_register_block sata_shadow_register_block_i (
    .clk, .rst, .reg_wr, .reg_rd, .reg_sel, .reg_wdata, .reg_rdata, .reg_rvalid, .cmd_start, .cmd_code,
    .busy_flag, .lba_mode, .device_select, .soft_reset_active, .frame_irq_force, .intrq, .status_low,
    .cmd_done, .cmd_done_ext, .current_lba, .interface_crc_error(err_in[5]), .uncorrectable_data_error(err_in[4]),
    .sector_id_not_found(err_in[3]), .command_aborted(err_in[2]), .track_zero_not_found(err_in[1]),
    .address_mark_not_found(err_in[0]), .send_dma_activate, .send_dma_setup, .setup_direction,
    .setup_auto_activate, .setup_irq, .setup_tag, .setup_buffer_offset, .setup_transfer_count,
    .send_set_dev_bits, .sdb_error, .sdb_status_hi, .sdb_status_lo, .sdb_notify, .sdb_irq, .sdb_active_mask,
    .frame_req_ready, .frame_valid, .frame_word, .frame_last, .frame_ready);
  frame_sink frame_sink_i (.slow, .clk, .rst, .frame_ready);

  always #5 clk = ~clk;

  task automatic check(input string what, input logic [35:0] seen, input logic [35:0] exp);
    cmp_count++;
    if (seen !== exp) begin
      failures++;
      $display("Error %s expected %h seen %h", what, exp, seen);
    end
  endtask : check

  task automatic report_and_stop;
    $display("comparisons %0d mismatches %0d", cmp_count, failures);
    if (failures == 0 && cmp_count > 0)
      $display("Test passed");
    else
      $display("Test failed");
    $finish;
  endtask : report_and_stop

  task automatic tick;
    @(posedge clk);
    #1;
  endtask : tick

  task automatic acc(input logic wr, input logic [3:0] sel, input logic [7:0] d);
    tick;
    reg_wr = wr;
    reg_rd = !wr;
    reg_sel = sel;
    reg_wdata = d;
    tick;
    reg_wr = 1'b0;
    reg_rd = 1'b0;
  endtask : acc

  task automatic wr_reg(input logic [3:0] sel, input logic [7:0] d);
    acc(1'b1, sel, d);
  endtask : wr_reg

  task automatic rd_reg(input logic [3:0] sel, input logic [7:0] exp);
    exp_rd.push_back(exp);
    acc(1'b0, sel, 8'h00);
  endtask : rd_reg

  task automatic pulse(input logic [5:0] e, input logic done);
    tick;
    err_in = e;
    cmd_done = done;
    cmd_done_ext = done;
    tick;
    err_in = 6'h00;
    cmd_done = 1'b0;
    cmd_done_ext = 1'b0;
  endtask : pulse

  task automatic send(input logic [2:0] s);
    tick;
    {send_dma_activate, send_dma_setup, send_set_dev_bits} = s;
    tick;
    {send_dma_activate, send_dma_setup, send_set_dev_bits} = 3'b000;
  endtask : send

  task automatic wait_drain;
    int n;
    n = 0;
    while (exp_fr.size() != 0 || exp_rd.size() != 0) begin
      tick;
      n++;
      if (n > 300) begin
        check("queue drain", 36'(exp_fr.size() + exp_rd.size()), 36'h0);
        report_and_stop;
      end
    end
  endtask : wait_drain

  // result monitor: oldest note against each answer
  always @(posedge clk) begin
    if (reg_rvalid)
      check("read data", reg_rdata, exp_rd.size() ? exp_rd.pop_front() : 8'hXX);
    if (frame_valid && frame_ready)
      check("frame word", {frame_last, frame_word}, exp_fr.size() ? exp_fr.pop_front() : 33'hX);
  end

  initial begin
    repeat (8) @(posedge clk);
    #1;
    rst = 1'b0;
    wr_reg(REG_DRIVE_HEAD, 8'h50);
    check("mode and select", {lba_mode, device_select}, 2'b11);
    wr_reg(REG_DRIVE_HEAD, 8'h00);
    check("mode and select", {lba_mode, device_select}, 2'b00);
    rd_reg(REG_DRIVE_HEAD, 8'h00);
    wr_reg(REG_ADDR_LOW, 8'hA1);
    wr_reg(REG_ADDR_LOW, 8'hB2);
    wr_reg(REG_DEVICE_CONTROL, 8'h80);
    rd_reg(REG_ADDR_LOW, 8'hA1);
    wr_reg(REG_ADDR_MID, 8'hC3);
    rd_reg(REG_ADDR_LOW, 8'hB2);
    rd_reg(REG_ADDR_MID, 8'hC3);
    $display("test address bytes done");
    for (int i = 0; i < 6; i++) begin
      interrupt_disable_n = (i == 4);
      dev = (i == 5);
      code = 8'hC8 + 8'(i);
      status_low = 7'($random(seed));
      lba = 48'({$random(seed), $random(seed)});
      current_lba = lba;
      wr_reg(REG_DEVICE_CONTROL, {6'h00, interrupt_disable_n, 1'b0});
      wr_reg(REG_DRIVE_HEAD, {3'b010, dev, 4'h0});
      wr_reg(REG_COMMAND, code);
      check("command launch", {cmd_start, busy_flag, cmd_code}, {2'b11, code});
      rd_reg(REG_ADDR_LOW, {1'b1, status_low});
      pulse(6'h01 << i, 1'b0);
      pulse(6'h00, 1'b1);
      check("completion", {busy_flag, intrq, frame_irq_force}, {1'b0, i < 4, interrupt_disable_n});
      rd_reg(REG_ERROR, 8'h01 << ebit[i]);
      rd_reg(REG_ADDR_LOW, lba[7:0]);
      rd_reg(REG_ADDR_MID, lba[15:8]);
      rd_reg(REG_ADDR_HIGH, lba[23:16]);
      rd_reg(REG_DRIVE_HEAD, {3'b010, dev, lba[27:24]});
      wr_reg(REG_DEVICE_CONTROL, {1'b1, 5'h00, interrupt_disable_n, 1'b0});
      rd_reg(REG_ADDR_LOW, lba[31:24]);
      rd_reg(REG_ADDR_MID, lba[39:32]);
      rd_reg(REG_COMMAND, {1'b0, status_low});
      check("interrupt after status read", intrq, 1'b0);
    end
    $display("test commands done");
    wr_reg(REG_DRIVE_HEAD, 8'h40);
    wr_reg(REG_DEVICE_CONTROL, 8'h04);
    wr_reg(REG_COMMAND, 8'hC8);
    check("held in reset", {busy_flag, cmd_start, soft_reset_active}, 3'b101);
    rd_reg(REG_ERROR, {1'b1, status_low});
    wr_reg(REG_DEVICE_CONTROL, 8'h00);
    tick;
    check("reset released", busy_flag, 1'b0);
    rd_reg(REG_DRIVE_HEAD, 8'h00);
    $display("test soft reset done");
    for (int j = 0; j < 2; j++) begin
      slow = !j[0];
      wr_reg(REG_DEVICE_CONTROL, {6'h00, j[0], 1'b0});
      {sdb_error, sdb_status_hi, sdb_status_lo, setup_tag, setup_direction, setup_auto_activate, setup_irq,
        sdb_notify, sdb_irq} = 24'($random(seed));
      setup_buffer_offset = $random(seed);
      setup_transfer_count = $random(seed);
      sdb_active_mask = $random(seed);
      exp_fr.push_back({1'b1, 24'h0, FRAME_DMA_ACTIVATE});
      send(3'b100);
      wait_drain;
      exp_fr.push_back({17'h0, setup_auto_activate, setup_irq | j[0], setup_direction, 5'h00, FRAME_DMA_SETUP});
      exp_fr.push_back({28'h0, setup_tag});
      exp_fr.push_back(33'h0);
      exp_fr.push_back(33'h0);
      exp_fr.push_back({1'b0, setup_buffer_offset});
      exp_fr.push_back({1'b0, setup_transfer_count});
      exp_fr.push_back({1'b1, 32'h0});
      send(3'b010);
      // stray request mid-frame must be dropped
      send(3'b100);
      wait_drain;
      exp_fr.push_back({1'b0, sdb_error, 1'b0, sdb_status_hi, 1'b0, sdb_status_lo, sdb_notify, sdb_irq | j[0],
        6'h00, FRAME_SET_DEV_BITS});
      exp_fr.push_back({1'b1, sdb_active_mask});
      send(3'b001);
      wait_drain;
    end
    $display("test frames done");
    wait_drain;
    repeat (3) tick;
    report_and_stop;
  end
endmodule : tb_sata_shadow_register_block
